// *** rtl/bus_pin_function_mux.sv ***
`timescale 1ns/1ns
// Notes on behaviour
// R1: strobe select set gives kind-specific address strobe
// R2: strobe select clear gives port9 bit4
// R3: advance select gives burst advance or column
// R4: advance select clear gives port9 bit5
// R5: write select gives write or sdram write
// R6: write select clear gives port9 bit6
// R7: address bits 0..15 always driven
// R8: bits 16..19 bus mode, else port6 0..3
// R9: i2c enabled: pins 20..22 open-drain i2c
// R10: software keeps port driver off for i2c
// R11: i2c off, bus used: address 20..22
// R12: i2c off, bus unused: port6 bits 4..6
// R13: priority i2c, then bus, then port
module bus_pin_function_mux
  import pin_mux_pkg::*;
(
  input  wire logic                CLOCK,
  input  wire logic                SRST,
  input  wire logic                CE,
  input  wire port9_function_reg_t PORT9_FUNC,
  input  wire mem_kind_t           MEM_KIND,
  input  wire logic                EXT_BUS_MODE,
  input  wire logic                I2C_ENABLE,
  input  wire strobes_t            STROBES,
  input  wire logic [22:0]         BUS_ADDR,
  input  wire gpio_bit_t [2:0]     PORT9_GPIO,
  input  wire gpio_bit_t [6:0]     PORT6_GPIO,
  input  wire logic [2:0]          I2C_DRIVE_LOW,
  input  wire logic [2:0]          SHARED_PIN_IN,
  output logic [2:0]               PIN9_OUT,
  output logic [2:0]               PIN9_OE,
  output logic [15:0]              ADDR_LOW_OUT,
  output logic [3:0]               NIBBLE_OUT,
  output logic [3:0]               NIBBLE_OE,
  output logic [2:0]               SHARED_OUT,
  output logic [2:0]               SHARED_OE,
  output logic [2:0]               SHARED_IN_SYNC
);

  // ==========================================================
  // strobe pins of port 9
  logic [2:0] pin9_out_r;
  logic [2:0] pin9_out_nxt;
  logic [2:0] pin9_oe_r;
  logic [2:0] pin9_oe_nxt;
  logic       strobe_sel;

  always_comb begin
    pin9_out_nxt = pin9_out_r;
    pin9_oe_nxt  = pin9_oe_r;
    case (MEM_KIND)
      MEM_BURST: strobe_sel = STROBES.burst_flash_addr_strobe;
      MEM_SDRAM: strobe_sel = STROBES.sdram_row_strobe;
      default:   strobe_sel = STROBES.addr_strobe_out;
    endcase
    if (CE) begin
      // R1: strobe by memory
      if (PORT9_FUNC.strobe_pin_select) begin
        pin9_out_nxt[0] = strobe_sel;
        pin9_oe_nxt[0]  = 1'h1;
      end else begin
        // R2: port bit four
        pin9_out_nxt[0] = PORT9_GPIO[0].dout;
        pin9_oe_nxt[0]  = PORT9_GPIO[0].oe;
      end
      // R3: advance or column
      if (PORT9_FUNC.advance_pin_select) begin
        pin9_out_nxt[1] = (MEM_KIND == MEM_SDRAM) ? STROBES.sdram_col_strobe
                                                  : STROBES.burst_addr_advance;
        pin9_oe_nxt[1]  = 1'h1;
      end else begin
        // R4: port bit five
        pin9_out_nxt[1] = PORT9_GPIO[1].dout;
        pin9_oe_nxt[1]  = PORT9_GPIO[1].oe;
      end
      // R5: write strobe
      if (PORT9_FUNC.write_pin_select) begin
        pin9_out_nxt[2] = (MEM_KIND == MEM_SDRAM) ? STROBES.sdram_write_enable
                                                  : STROBES.write_strobe;
        pin9_oe_nxt[2]  = 1'h1;
      end else begin
        // R6: port bit six
        pin9_out_nxt[2] = PORT9_GPIO[2].dout;
        pin9_oe_nxt[2]  = PORT9_GPIO[2].oe;
      end
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      pin9_out_r <= {3{STROBE_IDLE}};
      pin9_oe_r  <= PIN9_OE_RST;
    end else begin
      pin9_out_r <= pin9_out_nxt;
      pin9_oe_r  <= pin9_oe_nxt;
    end
  end

  assign PIN9_OUT = pin9_out_r;
  assign PIN9_OE  = pin9_oe_r;

  // ==========================================================
  // address pins 0..19
  logic [15:0] addr_low_r;
  logic [15:0] addr_low_nxt;
  logic [3:0]  nibble_r;
  logic [3:0]  nibble_nxt;
  logic [3:0]  nibble_oe_r;
  logic [3:0]  nibble_oe_nxt;

  always_comb begin
    addr_low_nxt  = addr_low_r;
    nibble_nxt    = nibble_r;
    nibble_oe_nxt = nibble_oe_r;
    if (CE) begin
      // R7: dedicated low address
      addr_low_nxt = BUS_ADDR[15:0];
      for (int i = 0; i < NIBBLE_W; i++) begin
        // R8: bus mode or port6
        if (EXT_BUS_MODE) begin
          nibble_nxt[i]    = BUS_ADDR[16+i];
          nibble_oe_nxt[i] = 1'h1;
        end else begin
          nibble_nxt[i]    = PORT6_GPIO[i].dout;
          nibble_oe_nxt[i] = PORT6_GPIO[i].oe;
        end
      end
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      addr_low_r  <= ADDR_LOW_RST;
      nibble_r    <= NIBBLE_RST;
      nibble_oe_r <= NIBBLE_RST;
    end else begin
      addr_low_r  <= addr_low_nxt;
      nibble_r    <= nibble_nxt;
      nibble_oe_r <= nibble_oe_nxt;
    end
  end

  assign ADDR_LOW_OUT = addr_low_r;
  assign NIBBLE_OUT   = nibble_r;
  assign NIBBLE_OE    = nibble_oe_r;

  // ==========================================================
  // shared pins: address 20..22, i2c, port6 bits 4..6
  logic [2:0] shared_r;
  logic [2:0] shared_nxt;
  logic [2:0] shared_oe_r;
  logic [2:0] shared_oe_nxt;

  generate
    for (genvar g = 0; g < SHARED_W; g++) begin : g_shared
      always_comb begin
        shared_nxt[g]    = shared_r[g];
        shared_oe_nxt[g] = shared_oe_r[g];
        if (CE) begin
          // R13: i2c, bus, port
          if (I2C_ENABLE) begin
            // R9: open-drain, low only
            shared_nxt[g]    = 1'h0;
            // R10: port6 enable is ORed in; software keeps it off
            shared_oe_nxt[g] = I2C_DRIVE_LOW[g] | PORT6_GPIO[4+g].oe;
          end else if (EXT_BUS_MODE) begin
            // R11: upper address
            shared_nxt[g]    = BUS_ADDR[20+g];
            shared_oe_nxt[g] = 1'h1;
          end else begin
            // R12: port6 bits
            shared_nxt[g]    = PORT6_GPIO[4+g].dout;
            shared_oe_nxt[g] = PORT6_GPIO[4+g].oe;
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      shared_r    <= SHARED_RST;
      shared_oe_r <= SHARED_RST;
    end else begin
      shared_r    <= shared_nxt;
      shared_oe_r <= shared_oe_nxt;
    end
  end

  assign SHARED_OUT = shared_r;
  assign SHARED_OE  = shared_oe_r;

  // ==========================================================
  // pin level back to the i2c controller; third stage confirms
  logic [2:0] sync1_r;
  logic [2:0] sync2_r;
  logic [2:0] sync3_r;
  logic [2:0] in_sync_r;
  logic [2:0] in_sync_nxt;

  always_comb begin
    in_sync_nxt = in_sync_r;
    for (int i = 0; i < SHARED_W; i++) begin
      if (sync2_r[i] == sync3_r[i]) begin
        in_sync_nxt[i] = sync3_r[i];
      end
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      sync1_r   <= SYNC_RST;
      sync2_r   <= SYNC_RST;
      sync3_r   <= SYNC_RST;
      in_sync_r <= SYNC_RST;
    end else if (CE) begin
      sync1_r   <= SHARED_PIN_IN;
      sync2_r   <= sync1_r;
      sync3_r   <= sync2_r;
      in_sync_r <= in_sync_nxt;
    end
  end

  assign SHARED_IN_SYNC = in_sync_r;

  // ==========================================================
  // checks
  a_strobe_select: assert property (@(posedge CLOCK) disable iff (SRST) // R1
    CE && PORT9_FUNC.strobe_pin_select |=> PIN9_OE[0] && PIN9_OUT[0] == $past(strobe_sel))
    else $error("strobe pin not driven");
  a_port9_bit4: assert property (@(posedge CLOCK) disable iff (SRST) // R2
    CE && !PORT9_FUNC.strobe_pin_select |=> PIN9_OE[0] == $past(PORT9_GPIO[0].oe))
    else $error("port9 bit4 enable wrong");
  a_advance_pin: assert property (@(posedge CLOCK) disable iff (SRST) // R3
    CE && PORT9_FUNC.advance_pin_select && MEM_KIND == MEM_SDRAM
    |=> PIN9_OUT[1] == $past(STROBES.sdram_col_strobe))
    else $error("column strobe wrong");
  a_port9_bit5: assert property (@(posedge CLOCK) disable iff (SRST) // R4
    CE && !PORT9_FUNC.advance_pin_select |=> PIN9_OUT[1] == $past(PORT9_GPIO[1].dout))
    else $error("port9 bit5 wrong");
  a_write_pin: assert property (@(posedge CLOCK) disable iff (SRST) // R5
    CE && PORT9_FUNC.write_pin_select && MEM_KIND != MEM_SDRAM
    |=> PIN9_OUT[2] == $past(STROBES.write_strobe) && PIN9_OE[2])
    else $error("write strobe wrong");
  a_port9_bit6: assert property (@(posedge CLOCK) disable iff (SRST) // R6
    CE && !PORT9_FUNC.write_pin_select |=> PIN9_OUT[2] == $past(PORT9_GPIO[2].dout))
    else $error("port9 bit6 wrong");
  a_addr_low: assert property (@(posedge CLOCK) disable iff (SRST) // R7
    CE |=> ADDR_LOW_OUT == $past(BUS_ADDR[15:0]))
    else $error("low address wrong");
  a_nibble_mode: assert property (@(posedge CLOCK) disable iff (SRST) // R8
    CE && EXT_BUS_MODE |=> NIBBLE_OE == 4'hF && NIBBLE_OUT == $past(BUS_ADDR[19:16]))
    else $error("upper nibble wrong");
  a_i2c_open: assert property (@(posedge CLOCK) disable iff (SRST) // R9
    CE && I2C_ENABLE |=> SHARED_OUT == 3'h0)
    else $error("i2c pin drives high");
  a_shared_addr: assert property (@(posedge CLOCK) disable iff (SRST) // R11
    CE && !I2C_ENABLE && EXT_BUS_MODE |=> SHARED_OUT == $past(BUS_ADDR[22:20]))
    else $error("shared address wrong");
  a_shared_port: assert property (@(posedge CLOCK) disable iff (SRST) // R12
    CE && !I2C_ENABLE && !EXT_BUS_MODE |=> SHARED_OE[0] == $past(PORT6_GPIO[4].oe))
    else $error("port6 bit4 wrong");
  a_i2c_priority: assert property (@(posedge CLOCK) disable iff (SRST) // R13
    CE && I2C_ENABLE && EXT_BUS_MODE && I2C_DRIVE_LOW == 3'h0 && !PORT6_GPIO[4].oe
    |=> !SHARED_OE[0])
    else $error("bus overrides i2c");
  a_freeze: assert property (@(posedge CLOCK) disable iff (SRST)
    !CE |=> $stable(PIN9_OUT) && $stable(SHARED_OUT))
    else $error("state moved while frozen");
  a_burst_strobe: assert property (@(posedge CLOCK) disable iff (SRST) // R1
    CE && PORT9_FUNC.strobe_pin_select && MEM_KIND == MEM_BURST
    |=> PIN9_OUT[0] == $past(STROBES.burst_flash_addr_strobe))
    else $error("burst address strobe wrong");
  a_burst_advance: assert property (@(posedge CLOCK) disable iff (SRST) // R3
    CE && PORT9_FUNC.advance_pin_select && MEM_KIND != MEM_SDRAM
    |=> PIN9_OUT[1] == $past(STROBES.burst_addr_advance) && PIN9_OE[1])
    else $error("burst advance wrong");
  a_sdram_write: assert property (@(posedge CLOCK) disable iff (SRST) // R5
    CE && PORT9_FUNC.write_pin_select && MEM_KIND == MEM_SDRAM
    |=> PIN9_OUT[2] == $past(STROBES.sdram_write_enable) && PIN9_OE[2])
    else $error("sdram write enable wrong");
  a_nibble_port: assert property (@(posedge CLOCK) disable iff (SRST) // R8
    CE && !EXT_BUS_MODE
    |=> NIBBLE_OUT[0] == $past(PORT6_GPIO[0].dout) && NIBBLE_OE[0] == $past(PORT6_GPIO[0].oe))
    else $error("port6 bit0 wrong");
  a_shared_bus_oe: assert property (@(posedge CLOCK) disable iff (SRST) // R11
    CE && !I2C_ENABLE && EXT_BUS_MODE |=> SHARED_OE == 3'h7)
    else $error("shared address not driven");
  a_i2c_pull: assert property (@(posedge CLOCK) disable iff (SRST) // R9
    CE && I2C_ENABLE && I2C_DRIVE_LOW[1] |=> SHARED_OE[1] && !SHARED_OUT[1])
    else $error("i2c clock not pulled low");
  // a level seen by only one stage must not reach the controller
  a_sync_hold: assert property (@(posedge CLOCK) disable iff (SRST)
    CE && sync2_r[0] != sync3_r[0] |=> SHARED_IN_SYNC[0] == $past(SHARED_IN_SYNC[0]))
    else $error("unconfirmed pin level passed");

  c_sdram_strobes: cover property (@(posedge CLOCK)
    CE && MEM_KIND == MEM_SDRAM && PORT9_FUNC == 3'h7);
  c_i2c_low: cover property (@(posedge CLOCK) CE && I2C_ENABLE && I2C_DRIVE_LOW != 3'h0);
  c_port_mode: cover property (@(posedge CLOCK) CE && !I2C_ENABLE && !EXT_BUS_MODE);
  c_bus_mode: cover property (@(posedge CLOCK) CE && !I2C_ENABLE && EXT_BUS_MODE);

endmodule : bus_pin_function_mux

// *** rtl/pin_mux_pkg.sv ***
package pin_mux_pkg;

  // ==========================================================
  // widths and reset values
  localparam int ADDR_LOW_W   = 16;
  localparam int NIBBLE_W     = 4;
  localparam int SHARED_W     = 3;
  localparam logic [15:0] ADDR_LOW_RST = 16'h0000;
  localparam logic [3:0]  NIBBLE_RST   = 4'h0;
  localparam logic [2:0]  SHARED_RST   = 3'h0;
  localparam logic [2:0]  PIN9_OE_RST  = 3'h0;
  // pulled-up pins read high until the filter sees otherwise
  localparam logic [2:0]  SYNC_RST     = 3'h7;
  // strobe pins idle high while held in reset
  localparam logic        STROBE_IDLE  = 1'h1;

  // ==========================================================
  // memory kinds steering the strobe pins
  typedef enum logic [1:0] {
    MEM_ASYNC = 2'h0,
    MEM_BURST = 2'h1,
    MEM_SDRAM = 2'h3
  } mem_kind_t;

  // port 9 function selects
  typedef struct packed {
    logic strobe_pin_select;
    logic advance_pin_select;
    logic write_pin_select;
  } port9_function_reg_t;

  // strobes from the bus controller
  typedef struct packed {
    logic addr_strobe_out;
    logic burst_flash_addr_strobe;
    logic sdram_row_strobe;
    logic burst_addr_advance;
    logic sdram_col_strobe;
    logic write_strobe;
    logic sdram_write_enable;
  } strobes_t;

  // one general-purpose port bit
  typedef struct packed {
    logic dout;
    logic oe;
  } gpio_bit_t;

endpackage : pin_mux_pkg

// *** sim/shared_pin_partner.sv ***
`timescale 1ns/1ns
// ==========================================================
// wired shared pins with pull-ups and a remote i2c device
module shared_pin_partner
  import pin_mux_pkg::*;
(
  input  wire logic [2:0] pin_out,
  input  wire logic [2:0] pin_oe,
  input  wire logic [2:0] remote_low,
  output logic [2:0]      pin_level
);
  always_comb begin
    for (int g = 0; g < SHARED_W; g++) begin
      // pull-up wins only when nobody pulls low
      pin_level[g] = !remote_low[g] && !(pin_oe[g] && !pin_out[g]);
    end
  end
endmodule : shared_pin_partner

// *** sim/testbench.sv ***
`timescale 1ns/1ns
module testbench
  import pin_mux_pkg::*;
;
  logic                clock = 1'b0;
  logic                srst  = 1'b1;
  logic                ce    = 1'b1;
  logic                ext   = 1'b0;
  logic                i2c   = 1'b0;
  port9_function_reg_t pf    = '0;
  mem_kind_t           mk    = MEM_ASYNC;
  strobes_t            st    = '0;
  logic [22:0]         addr  = '0;
  gpio_bit_t [2:0]     p9    = '0;
  gpio_bit_t [6:0]     p6    = '0;
  logic [2:0]          dl    = '0;
  logic [2:0]          rl    = '0;
  logic [2:0]          lvl, p9o, p9e, sho, she, syn, x9o, x9e, xso, xse;
  logic [15:0]         alo, xlo;
  logic [3:0]          nbo, nbe, xno, xne;
  int                  bad_count = 0;
  int                  n_tests   = 0;
  int                  cycles    = 0;

  always #5 clock = ~clock;

  bus_pin_function_mux uut (
    .CLOCK(clock), .SRST(srst), .CE(ce), .PORT9_FUNC(pf), .MEM_KIND(mk),
    .EXT_BUS_MODE(ext), .I2C_ENABLE(i2c), .STROBES(st), .BUS_ADDR(addr),
    .PORT9_GPIO(p9), .PORT6_GPIO(p6), .I2C_DRIVE_LOW(dl), .SHARED_PIN_IN(lvl),
    .PIN9_OUT(p9o), .PIN9_OE(p9e), .ADDR_LOW_OUT(alo), .NIBBLE_OUT(nbo),
    .NIBBLE_OE(nbe), .SHARED_OUT(sho), .SHARED_OE(she), .SHARED_IN_SYNC(syn));

  shared_pin_partner far_side (
    .pin_out(sho), .pin_oe(she), .remote_low(rl), .pin_level(lvl));

  // ==========================================================
  // checking and closing
  task automatic check(input logic [22:0] got, input logic [22:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : stop_test

  // hang guard, the run needs about 280 cycles
  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      bad_count++;
      stop_test();
    end
  end

  // ==========================================================
  // expected pin functions from the current inputs
  task automatic calc();
    logic sd;
    sd = (mk == MEM_SDRAM);
    xlo = addr[15:0];
    x9o[0] = pf.strobe_pin_select ? (sd ? st.sdram_row_strobe :
             (mk == MEM_BURST) ? st.burst_flash_addr_strobe : st.addr_strobe_out) : p9[0].dout;
    x9o[1] = pf.advance_pin_select ? (sd ? st.sdram_col_strobe : st.burst_addr_advance)
             : p9[1].dout;
    x9o[2] = pf.write_pin_select ? (sd ? st.sdram_write_enable : st.write_strobe) : p9[2].dout;
    x9e = {pf.write_pin_select, pf.advance_pin_select, pf.strobe_pin_select}
          | {p9[2].oe, p9[1].oe, p9[0].oe};
    for (int g = 0; g < 4; g++) begin
      xno[g] = ext ? addr[16+g] : p6[g].dout;
      xne[g] = ext | p6[g].oe;
    end
    for (int g = 0; g < 3; g++) begin
      xso[g] = i2c ? 1'b0 : ext ? addr[20+g] : p6[4+g].dout;
      xse[g] = i2c ? (dl[g] | p6[4+g].oe) : (ext | p6[4+g].oe);
    end
  endtask : calc

  task automatic compare_all();
    check(p9o, x9o);
    check(p9e, x9e);
    check(alo, xlo);
    check(nbo, xno);
    check(nbe, xne);
    check(sho, xso);
    check(she, xse);
  endtask : compare_all

  task automatic do_reset();
    srst = 1'b1;
    repeat (2) @(negedge clock);
    srst = 1'b0;
    check(p9o, {3{STROBE_IDLE}});
    check(p9e, PIN9_OE_RST);
    check(alo, ADDR_LOW_RST);
    check(nbo, NIBBLE_RST);
    check(nbe, NIBBLE_RST);
    check(sho, SHARED_RST);
    check(she, SHARED_RST);
    check(syn, SYNC_RST);
  endtask : do_reset

  // ==========================================================
  // main sequence
  initial begin
    do_reset();
    // every select, memory kind and mode combination
    for (int i = 0; i < 256; i++) begin
      pf   = port9_function_reg_t'(i[2:0]);
      mk   = mem_kind_t'(i[4:3]);
      ext  = i[5];
      i2c  = i[6];
      st   = strobes_t'(7'(i * 37 + i[7]));
      addr = 23'(i * 12345 + 23'h5A5A5A);
      p9   = 6'(i * 7);
      p6   = 14'(i * 11 + 3);
      dl   = 3'(i + i[7]);
      @(negedge clock);
      calc();
      compare_all();
    end
    // frozen while the clock enable is low
    ce   = 1'b0;
    addr = ~addr;
    pf   = ~pf;
    repeat (3) @(negedge clock);
    compare_all();
    ce = 1'b1;
    @(negedge clock);
    calc();
    compare_all();
    // port drivers stay off in i2c mode
    i2c = 1'b1;
    p6  = '0;
    dl  = 3'h4;
    rl  = 3'h2;
    repeat (6) @(negedge clock);
    check(syn, 3'h1);
    check(she, 3'h4);
    dl = 3'h0;
    rl = 3'h0;
    repeat (6) @(negedge clock);
    check(syn, 3'h7);
    do_reset();
    stop_test();
  end
endmodule : testbench
